// ===== hw/i2c_status_and_address_mask.sv
// I2C slave status flags, address mask and AXI4-Lite register file
`timescale 1ns/100ps
`default_nettype none
module i2c_status_and_address_mask
  import i2c_stat_pkg::*;
(
  input wire logic aclk, // Block clock, 40 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic scl_i, // Bus clock line level
  input wire logic sda_i, // Bus data line level
  output logic sda_o, // Data line drive value
  output logic sda_oe, // Data line driven low while high
  output logic irq // Level interrupt
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [MASK_W-1:0] mask;
    logic [7:0] rcv;
    logic [7:0] trn;
    logic [7:0] sh;
    logic [3:0] cnt;
    phase_t ph;
    logic acknowledge_result_flag;
    logic data_addr;
    logic stop;
    logic start;
    logic rw;
    logic rx_full;
    logic tx_full;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic sda_oe;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } blk_t;

  blk_t r;
  blk_t next_r;
  line_ev_t ev;
  logic hit;

  // Byte-enable mask for a 16-bit register
  function automatic logic [15:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Merge of old and written bits under byte enables
  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] strb);
    merge = (old & ~lanes(strb)) | (d[15:0] & lanes(strb));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  i2c_line_monitor u_mon (
    .aclk (aclk),
    .aresetn (aresetn),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev (ev)
  );

  // Seven-bit addressing: the address sits in sh[7:1]
  i2c_addr_match #(.ADDR_W(7)) u_match (
    .rx_addr (r.sh[7:1]),
    .own_addr (r.ctrl[6:0]),
    .mask (r.mask[6:0]),
    .hit (hit)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [IRQ_W-1:0] set_ev;
    logic rd_rcv;
    logic do_wr;
    logic [15:0] st_word;
    logic [15:0] mask_word;
    set_ev = '0;
    mask_word = '0;
    rd_rcv = 1'b0;
    do_wr = 1'b0;
    st_word = '0;
    next_r = r;

    // Bus engine
    if (ev.start)
    begin
      next_r.start = 1'b1;
      next_r.stop = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.cnt = '0;
      next_r.ph = r.ctrl[CTRL_ENABLE_BIT] ? PH_ADDR : PH_IDLE;
    end
    else if (ev.stop)
    begin
      next_r.stop = 1'b1;
      next_r.start = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.ph = PH_IDLE;
      set_ev[IRQ_STOP_BIT] = 1'b1;
    end
    else
    begin
      case (r.ph)
        PH_IDLE:
          next_r.sda_oe = 1'b0;
        PH_ADDR, PH_RXD:
        begin
          if (ev.scl_rise && r.cnt != BYTE_BITS)
          begin
            next_r.sh = {r.sh[6:0], ev.sda};
            next_r.cnt = r.cnt + 4'h1;
          end
          else if (ev.scl_fall && r.cnt == BYTE_BITS)
          begin
            if (r.ph == PH_RXD)
            begin
              next_r.rcv = r.sh;
              next_r.rx_full = 1'b1;
              next_r.data_addr = 1'b1;
              next_r.sda_oe = 1'b1;
              next_r.ph = PH_ACK_R;
              set_ev[IRQ_RX_BIT] = 1'b1;
            end
            else if (hit)
            begin
              next_r.data_addr = 1'b0;
              next_r.rw = r.sh[0];
              next_r.sda_oe = 1'b1;
              next_r.ph = PH_ACK_A;
              set_ev[IRQ_ADDR_BIT] = 1'b1;
            end
            else
              next_r.ph = PH_IDLE;
          end
        end
        PH_ACK_A, PH_ACK_R:
        begin
          if (ev.scl_fall)
          begin
            next_r.cnt = '0;
            if (r.ph == PH_ACK_A && r.rw)
            begin
              next_r.sh = r.trn;
              next_r.sda_oe = ~r.trn[7];
              next_r.ph = PH_TXD;
            end
            else
            begin
              next_r.sda_oe = 1'b0;
              next_r.ph = PH_RXD;
            end
          end
        end
        PH_TXD:
        begin
          if (ev.scl_rise)
          begin
            next_r.sh = {r.sh[6:0], 1'b1};
            next_r.cnt = r.cnt + 4'h1;
          end
          else if (ev.scl_fall)
          begin
            // Data line released for the master's answer after bit 0
            next_r.sda_oe = (r.cnt == BYTE_BITS) ? 1'b0 : ~r.sh[7];
            if (r.cnt == BYTE_BITS)
              next_r.ph = PH_ACK_T;
          end
        end
        PH_ACK_T:
        begin
          if (ev.scl_rise)
          begin
            next_r.acknowledge_result_flag = ev.sda;
            next_r.tx_full = 1'b0;
            set_ev[IRQ_TX_BIT] = 1'b1;
          end
          else if (ev.scl_fall)
          begin
            // A refused byte ends the read; wait for the stop
            next_r.cnt = '0;
            next_r.sh = r.trn;
            next_r.sda_oe = r.acknowledge_result_flag ? 1'b0 : ~r.trn[7];
            next_r.ph = r.acknowledge_result_flag ? PH_IDLE : PH_TXD;
          end
        end
        default:
        begin
          next_r.sda_oe = 1'b0;
          next_r.ph = PH_IDLE;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data in either order
    if (s_axi_awvalid && r.awready)
    begin
      next_r.aw_held = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.w_held = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    do_wr = r.aw_held && r.w_held && !r.bvalid;
    if (do_wr)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        OFS_CONTROL:
          next_r.ctrl = merge(r.ctrl, r.wdata, r.wstrb);
        OFS_ADDR_MASK:
        begin
          mask_word = merge({6'h00, r.mask}, r.wdata, r.wstrb);
          next_r.mask = mask_word[MASK_W-1:0];
        end
        OFS_TRANSMIT:
          if (r.wstrb[0])
          begin
            next_r.trn = r.wdata[7:0];
            next_r.tx_full = 1'b1;
          end
        OFS_IRQ_MASK:
          if (r.wstrb[0])
            next_r.irq_en = r.wdata[IRQ_W-1:0];
        OFS_IRQ_STATUS:
          if (r.wstrb[0])
            next_r.irq_st = r.irq_st & ~r.wdata[IRQ_W-1:0];
        OFS_BUS_STATUS, OFS_RECEIVE: ;
        default:
          next_r.bresp = RESP_SLVERR;
      endcase
    end
    next_r.awready = !next_r.aw_held;
    next_r.wready = !next_r.w_held;

    // AXI4-Lite read side
    st_word[ST_ACK_BIT] = r.acknowledge_result_flag;
    st_word[ST_DATA_ADDR_BIT] = r.data_addr;
    st_word[ST_STOP_BIT] = r.stop;
    st_word[ST_START_BIT] = r.start;
    st_word[ST_READ_WRITE_BIT] = r.rw;
    st_word[ST_RX_FULL_BIT] = r.rx_full;
    st_word[ST_TX_FULL_BIT] = r.tx_full;
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready)
    begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      case (s_axi_araddr)
        OFS_CONTROL:
          next_r.rdata[15:0] = r.ctrl;
        OFS_BUS_STATUS:
          next_r.rdata[15:0] = st_word;
        OFS_ADDR_MASK:
          next_r.rdata[MASK_W-1:0] = r.mask;
        OFS_RECEIVE:
        begin
          next_r.rdata[7:0] = r.rcv;
          rd_rcv = 1'b1;
        end
        OFS_TRANSMIT:
          next_r.rdata[7:0] = r.trn;
        OFS_IRQ_STATUS:
          next_r.rdata[IRQ_W-1:0] = r.irq_st;
        OFS_IRQ_MASK:
          next_r.rdata[IRQ_W-1:0] = r.irq_en;
        default:
          next_r.rresp = RESP_SLVERR;
      endcase
    end
    // A byte landing in the same cycle as the read keeps the flag up
    if (rd_rcv && !(next_r.rcv != r.rcv || set_ev[IRQ_RX_BIT]))
      next_r.rx_full = 1'b0;

    // Sticky events; a new event beats a clear in the same cycle
    next_r.irq_st = next_r.irq_st | set_ev;
    next_r.irq = |(next_r.irq_st & next_r.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.ctrl <= RST_CONTROL;
      r.mask <= RST_ADDR_MASK;
      r.irq_en <= RST_IRQ_MASK;
      r.ph <= PH_IDLE;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign sda_o = r.sh[0] & 1'b0;
  assign sda_oe = r.sda_oe;
  assign irq = r.irq;
endmodule // i2c_status_and_address_mask
`default_nettype wire

// ===== hw/i2c_stat_pkg.sv
// Constants, offsets and carrier types of the I2C status and mask block
package i2c_stat_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BUS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR_MASK = 8'h08;
  localparam logic [7:0] OFS_RECEIVE = 8'h0c;
  localparam logic [7:0] OFS_TRANSMIT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 15;
  localparam int OWN_ADDR_W = 10;
  // Bus status register fields
  localparam int ST_ACK_BIT = 15;
  localparam int ST_DATA_ADDR_BIT = 5;
  localparam int ST_STOP_BIT = 4;
  localparam int ST_START_BIT = 3;
  localparam int ST_READ_WRITE_BIT = 2;
  localparam int ST_RX_FULL_BIT = 1;
  localparam int ST_TX_FULL_BIT = 0;
  // Address mask width; bits above read as zero
  localparam int MASK_W = 10;
  // Interrupt status and mask fields
  localparam int IRQ_W = 4;
  localparam int IRQ_ADDR_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_TX_BIT = 2;
  localparam int IRQ_STOP_BIT = 3;
  // Reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [MASK_W-1:0] RST_ADDR_MASK = 10'h000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Bit count of one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Line events seen on the sampled bus
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } line_ev_t;

  typedef enum logic [6:0] {
    PH_IDLE = 7'h01,
    PH_ADDR = 7'h02,
    PH_ACK_A = 7'h04,
    PH_RXD = 7'h08,
    PH_ACK_R = 7'h10,
    PH_TXD = 7'h20,
    PH_ACK_T = 7'h40
  } phase_t;
endpackage

// ===== hw/i2c_line_monitor.sv
// Synchroniser and start/stop/edge detector for the two bus lines
`timescale 1ns/100ps
`default_nettype none
module i2c_line_monitor
  import i2c_stat_pkg::*;
(
  input wire logic aclk, // Block clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic scl_i, // Clock line level
  input wire logic sda_i, // Data line level
  output line_ev_t ev // Decoded line events
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
  } mon_t;

  mon_t r;
  mon_t next_r;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    next_r.scl_m = scl_i;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = sda_i;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Only the second and third stages are looked at
  always_comb
  begin
    ev.scl_rise = r.scl_s & ~r.scl_d;
    ev.scl_fall = ~r.scl_s & r.scl_d;
    ev.start = r.scl_s & r.scl_d & ~r.sda_s & r.sda_d;
    ev.stop = r.scl_s & r.scl_d & r.sda_s & ~r.sda_d;
    ev.sda = r.sda_s;
  end
endmodule // i2c_line_monitor
`default_nettype wire

// ===== hw/i2c_addr_match.sv
// Masked comparison of a received address against the own address
`timescale 1ns/100ps
`default_nettype none
module i2c_addr_match
  import i2c_stat_pkg::*;
#(
  parameter int ADDR_W = 7
)(
  input wire logic [ADDR_W-1:0] rx_addr, // Address bits from the wire
  input wire logic [ADDR_W-1:0] own_addr, // Configured slave address
  input wire logic [ADDR_W-1:0] mask, // 1 excuses a bit position
  output logic hit // All unmasked bits agree
);
  logic [ADDR_W-1:0] bit_ok;

  genvar i;
  generate
    for (i = 0; i < ADDR_W; i++)
    begin : g_bit
      assign bit_ok[i] = mask[i] | (rx_addr[i] == own_addr[i]);
    end
  endgenerate

  assign hit = &bit_ok;
endmodule // i2c_addr_match
`default_nettype wire

// ===== tb/i2c_status_and_address_mask_asserts.sv
// Bus and line assertions for the I2C status and mask block
`timescale 1ns/100ps
`default_nettype none
module i2c_status_and_address_mask_asserts
  import i2c_stat_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic scl_i, // Bus clock line
  input wire logic sda_o, // Data drive value
  input wire logic sda_oe // Data drive enable
);
  logic [7:0] rd_addr;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Address of the read in flight, to judge what rdata carries
  always_ff @(posedge aclk)
    if (!aresetn)
      rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;

  ////////////////////////////////////////////////////////////////////////////
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles on");
  unmapped_read_a: assert property (s_axi_rvalid && rd_addr > OFS_IRQ_MASK
    |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  mask_upper_a: assert property (s_axi_rvalid && rd_addr == OFS_ADDR_MASK |->
    s_axi_rdata[31:10] == 22'h0) else $error("mask upper bits not zero");
  flag_exclusive_a: assert property (s_axi_rvalid &&
    rd_addr == OFS_BUS_STATUS |->
    !(s_axi_rdata[ST_START_BIT] && s_axi_rdata[ST_STOP_BIT]))
    else $error("start and stop flags both set");
  sda_steady_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock high");
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
endmodule // i2c_status_and_address_mask_asserts

bind i2c_status_and_address_mask i2c_status_and_address_mask_asserts chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .scl_i, .sda_o, .sda_oe);
`default_nettype wire

// ===== tb/i2c_bus_master_model.sv
// Behavioural I2C bus master driving the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model
(
  input wire logic sda_oe, // Slave pulls data low while high
  output logic scl, // Bus clock line
  output logic sda // Data line level seen by all
);
  logic sda_m;

  // Pull-up line: low whenever either side pulls it
  assign sda = sda_m & ~sda_oe;

  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Long low phase leaves room for the slave's synchroniser delay
  task automatic bit_io(input logic d, output logic q);
    #75 sda_m = d;
    #75 scl = 1'b1;
    #25 q = sda;
    #25 scl = 1'b0;
  endtask

  task automatic start_cond;
    sda_m = 1'b1;
    scl = 1'b1;
    #100 sda_m = 1'b0;
    #100 scl = 1'b0;
  endtask

  // Clock stands high after a stop until the next frame
  task automatic stop_cond;
    #75 sda_m = 1'b0;
    #75 scl = 1'b1;
    #100 sda_m = 1'b1;
    #100;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    int i;
    logic q;
    for (i = 7; i >= 0; i--)
      bit_io(b[i], q);
    bit_io(1'b1, ack_n);
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] b);
    int i;
    logic q;
    for (i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(nack, q);
  endtask
endmodule // i2c_bus_master_model
`default_nettype wire

// ===== tb/i2c_status_and_address_mask_tb_top.sv
// Self-checking bench for the I2C status and mask block
`timescale 1ns/100ps
`default_nettype none
module i2c_status_and_address_mask_tb_top;
  import i2c_stat_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl, sda, sda_o, sda_oe;
  logic irq, ack_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, byte_in;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0;
  int num_checks = 0;

  i2c_status_and_address_mask dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
    .irq);
  i2c_bus_master_model m (.sda_oe, .scl, .sda);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(n < 50), 32'h1, "write answer");
    chk(32'(s_axi_bresp), 32'(er), "write response");
    if (n == 50)
      conclude();
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er,
    output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(n < 50), 32'h1, "read answer");
    chk(32'(s_axi_rresp), 32'(er), "read response");
    if (n == 50)
      conclude();
  endtask

  // Only the bits under the mask are judged
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd_reg(a, RESP_OKAY, d);
    chk(d & m, exp, what);
  endtask

  task automatic irq_is(input logic e, input string what);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'(e), what);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(OFS_BUS_STATUS, 32'hffffffff, 32'h0, "status at reset");
    rdc(OFS_ADDR_MASK, 32'hffffffff, 32'h0, "mask at reset");
    wr(OFS_ADDR_MASK, 32'hffffffff, RESP_OKAY);
    rdc(OFS_ADDR_MASK, 32'hffffffff, 32'h3ff, "mask width");
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd_reg(8'h40, RESP_SLVERR, rd);
    chk(rd, 32'h0, "unmapped read");
    wr(OFS_ADDR_MASK, 32'h0, RESP_OKAY);
    $display("test registers done");
  endtask

  task automatic t_write_xfer;
    wr(OFS_CONTROL, 32'h802a, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'hf, RESP_OKAY);
    m.start_cond();
    m.send_byte(8'h54, ack_n);
    chk(32'(ack_n), 32'h0, "address ack");
    // Acknowledge result is left out while receiving
    rdc(OFS_BUS_STATUS, 32'h3f, 32'h08, "after address");
    irq_is(1'b1, "address irq");
    m.send_byte(8'ha5, ack_n);
    chk(32'(ack_n), 32'h0, "data ack");
    rdc(OFS_BUS_STATUS, 32'h3f, 32'h2a, "after data");
    rdc(OFS_RECEIVE, 32'hff, 32'ha5, "received byte");
    rdc(OFS_BUS_STATUS, 32'h2, 32'h0, "receive flag after read");
    m.stop_cond();
    rdc(OFS_BUS_STATUS, 32'h18, 32'h10, "after stop");
    wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    irq_is(1'b0, "masked irq");
    wr(OFS_IRQ_MASK, 32'hf, RESP_OKAY);
    irq_is(1'b1, "unmasked irq");
    wr(OFS_IRQ_STATUS, 32'hf, RESP_OKAY);
    irq_is(1'b0, "cleared irq");
    $display("test write transfer done");
  endtask

  task automatic t_match;
    int i;
    int k;
    logic [6:0] a;
    for (i = 0; i < 7; i++)
      for (k = 0; k < 2; k++)
      begin
        a = 7'h2a ^ (7'h01 << i);
        wr(OFS_ADDR_MASK, k ? 32'h1 << i : 32'h0, RESP_OKAY);
        m.start_cond();
        m.send_byte({a, 1'b0}, ack_n);
        chk(32'(ack_n), k ? 32'h0 : 32'h1, "masked match");
        m.stop_cond();
      end
    wr(OFS_ADDR_MASK, 32'h0, RESP_OKAY);
    $display("test address mask done");
  endtask

  task automatic t_read_xfer;
    wr(OFS_TRANSMIT, 32'h3c, RESP_OKAY);
    rdc(OFS_BUS_STATUS, 32'h1, 32'h1, "transmit flag set");
    m.start_cond();
    m.send_byte(8'h55, ack_n);
    chk(32'(ack_n), 32'h0, "read address ack");
    rdc(OFS_BUS_STATUS, 32'h4, 32'h4, "read direction");
    m.recv_byte(1'b0, byte_in);
    chk(32'(byte_in), 32'h3c, "sent byte");
    rdc(OFS_BUS_STATUS, 32'h8001, 32'h0, "after acked byte");
    m.recv_byte(1'b1, byte_in);
    chk(32'(byte_in), 32'h3c, "reloaded byte");
    rdc(OFS_BUS_STATUS, 32'h8000, 32'h8000, "after nacked byte");
    m.stop_cond();
    $display("test read transfer done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aresetn <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_write_xfer();
    t_match();
    t_read_xfer();
    conclude();
  end
endmodule // i2c_status_and_address_mask_tb_top
`default_nettype wire
